/* File: sim/efbp_flash_model.sv */
// Behavioural flash die on the far side of the controller.
// Assumes the bench resolves shared data lines and pull-ups.
`timescale 1ns/1ns
module efbp_flash_model (
    input wire logic [20:0] addr,
    input wire logic [15:0] dq,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_strobe_n,
    input wire logic reset_power_down_n,
    output logic [15:0] q,
    output logic q_en,
    output logic busy = 1'b0
);
    // Full decode, so unmasked top bits land elsewhere
    logic [15:0] mem [logic [20:0]];
    // Write protect sits high on the board; no lock modelled
    always @(posedge wr_strobe_n) begin
        if (!chip_sel_n && reset_power_down_n) begin
            mem[addr] = dq;
            busy = 1'b1;
            // Off the clock grid, so the sampled busy level never races
            #55 busy = 1'b0;
        end
    end
    assign q_en = !chip_sel_n && !out_en_n && reset_power_down_n;
    // Released lines flip each change, never keep the last word
    always @(q_en or addr) begin
        if (q_en)
            q = mem.exists(addr) ? mem[addr] : 16'hffff;
        else
            q = ~q;
    end
endmodule // efbp_flash_model

/* File: sim/efbp_monitor.sv */
// Checker on the controller's flash pins.
// Assumes it is bound to efbp_ctrl; one clock domain.
`timescale 1ns/1ns
module efbp_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic own_bus,
    input wire logic chip_sel_n_o,
    input wire logic out_en_n_o,
    input wire logic wr_strobe_n_o,
    input wire logic dq_oe,
    input wire logic ctrl_oe,
    input wire logic addr_oe,
    input wire logic reset_power_down_n_o,
    input wire logic reset_power_down_n_oe,
    input wire logic [1:0] density,
    input wire logic [20:0] addr_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_read_released: assert property (!out_en_n_o |-> !dq_oe)
        else $error("data driven during read");
    a_we_width: assert property ($fell(wr_strobe_n_o) |->
        !wr_strobe_n_o[*7]) else $error("write pulse short");
    a_oe_width: assert property ($fell(out_en_n_o) |->
        (!out_en_n_o && !chip_sel_n_o)[*7]) else $error("read short");
    a_we_setup: assert property ($fell(wr_strobe_n_o) |->
        !$past(chip_sel_n_o, 4) && $past(dq_oe, 4))
        else $error("write setup short");
    a_we_hold: assert property ($rose(wr_strobe_n_o) |->
        (dq_oe && !chip_sel_n_o)[*2]) else $error("write hold short");
    a_addr_mask: assert property (!chip_sel_n_o && density != 0 |->
        (addr_o >> (21 - density)) == 21'h0) else $error("top bits set");
    a_park_release: assert property (
        (!own_bus && chip_sel_n_o && reset_power_down_n_o)[*6] |->
        !ctrl_oe && !addr_oe && !dq_oe && !reset_power_down_n_oe)
        else $error("bus kept while not owned");
    a_reset_width: assert property ($fell(reset_power_down_n_o) |->
        (!reset_power_down_n_o && wr_strobe_n_o)[*8])
        else $error("reset pulse short");
    c_write: cover property ($fell(wr_strobe_n_o));
    c_read: cover property ($fell(out_en_n_o));
    c_reset: cover property ($fell(reset_power_down_n_o));
    c_park: cover property ($fell(ctrl_oe));
endmodule // efbp_monitor

/* File: sim/tb_top.sv */
// Bench for efbp_ctrl against the flash model.
// Assumes the design and model files are compiled first.
`timescale 1ns/1ns
module tb_top;
    typedef struct {logic [1:0] dn; logic [20:0] wa, ra;
        logic [15:0] wd, ex;} efbp_row_t;
    logic clk, rst, own_bus, req_valid, req_write, req_reset, q_en, busy;
    logic req_ready, rsp_valid, flash_ready, addr_oe, dq_oe, ctrl_oe;
    logic chip_sel_n_o, out_en_n_o, wr_strobe_n_o;
    logic reset_power_down_n_o, reset_power_down_n_oe;
    logic [1:0] density;
    logic [20:0] req_addr, addr_o;
    logic [15:0] req_wdata, rsp_rdata, dq_o, fq;
    wire [15:0] dq_i = dq_oe ? dq_o : fq;
    wire ready_busy_n_i = !busy;
    int mismatches = 0;
    int check_count = 0;
    int rp_low = 0;
    int rp_mark = 0;
    efbp_row_t rows [5] = '{'{2'h0, 21'h000005, 21'h000005, 16'h1234, 16'h1234},
        '{2'h3, 21'h1c0010, 21'h000010, 16'hbeef, 16'hbeef},
        '{2'h1, 21'h0fffff, 21'h0fffff, 16'h8001, 16'h8001},
        '{2'h2, 21'h1fffff, 21'h07ffff, 16'h0001, 16'h0001},
        '{2'h0, 21'h1fffff, 21'h1fffff, 16'ha5a5, 16'ha5a5}};
    efbp_ctrl dut (.clk, .rst, .own_bus, .density, .req_valid, .req_ready,
        .req_write, .req_reset, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
        .flash_ready, .addr_o, .addr_oe, .dq_i, .dq_o, .dq_oe, .chip_sel_n_o,
        .out_en_n_o, .wr_strobe_n_o, .ctrl_oe, .reset_power_down_n_o,
        .reset_power_down_n_oe, .ready_busy_n_i);
    efbp_flash_model flash (.addr(addr_o & {21{addr_oe}}), .dq(dq_i),
        .chip_sel_n(!ctrl_oe | chip_sel_n_o), .out_en_n(!ctrl_oe | out_en_n_o),
        .wr_strobe_n(!ctrl_oe | wr_strobe_n_o),
        .reset_power_down_n(!reset_power_down_n_oe | reset_power_down_n_o),
        .q(fq), .q_en(q_en), .busy(busy));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string n, logic [20:0] e, logic [20:0] s);
        check_count++;
        if (e !== s) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic xfer(logic w, logic r, logic [20:0] a, logic [15:0] d);
        int i;
        {req_write, req_reset, req_addr, req_wdata} = {w, r, a, d};
        req_valid = 1'b1;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(posedge clk) #1;
        if (req_ready !== 1'b1) begin
            mismatches++;
            $display("mismatch req_ready expected 1 seen %b", req_ready);
            wrap_up();
        end
        @(posedge clk) #1;
        req_valid = 1'b0;
        for (i = 0; i < 50 && rsp_valid !== 1'b1; i++) @(posedge clk) #1;
        if (rsp_valid !== 1'b1) begin
            mismatches++;
            $display("mismatch rsp_valid expected 1 seen %b", rsp_valid);
            wrap_up();
        end
    endtask
    // Data lines driven by both ends at once
    always @(posedge clk) begin
        if (q_en && dq_oe) begin
            mismatches++;
            $display("mismatch dq_drivers expected 1 seen 2");
        end
    end
    // Cycles with the reset line low, sampled before each edge's update
    always @(posedge clk) begin
        if (reset_power_down_n_o === 1'b0) begin
            rp_low++;
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst, own_bus, density, req_valid, req_write, req_reset} = 7'h60;
        {req_addr, req_wdata} = 37'h0;
        repeat (3) @(posedge clk) #1;
        chk("cs_n", 1, chip_sel_n_o);
        chk("ctrl_oe", 0, ctrl_oe);
        rst = 1'b0;
        foreach (rows[k]) begin
            density = rows[k].dn;
            xfer(1'b1, 1'b0, rows[k].wa, rows[k].wd);
            xfer(1'b0, 1'b0, rows[k].ra, 16'h0);
            chk("rdata", rows[k].ex, rsp_rdata);
            $display("row %0d done", k);
        end
        xfer(1'b1, 1'b0, 21'h000040, 16'h00ff);
        chk("busy", 0, flash_ready);
        repeat (10) @(posedge clk) #1;
        chk("ready", 1, flash_ready);
        rp_mark = rp_low;
        xfer(1'b0, 1'b1, 21'h0, 16'h0);
        chk("rp_n", 1, reset_power_down_n_o);
        chk("rp_w", efbp_pkg::EFBP_T_RST_CYC + 1, rp_low - rp_mark);
        xfer(1'b0, 1'b0, 21'h000005, 16'h0);
        chk("kept", 16'h1234, rsp_rdata);
        $display("busy and reset done");
        // Reset in mid-access: pins must drop back at once
        req_write = 1'b1;
        req_reset = 1'b0;
        req_valid = 1'b1;
        repeat (4) @(posedge clk) #1;
        req_valid = 1'b0;
        chk("mid_cs_n", 0, chip_sel_n_o);
        rst = 1'b1;
        #1;
        chk("rst_cs_n", 1, chip_sel_n_o);
        chk("rst_we_n", 1, wr_strobe_n_o);
        chk("rst_dq_oe", 0, dq_oe);
        @(posedge clk) #1;
        rst = 1'b0;
        @(posedge clk) #1;
        chk("rst_ready", 1, req_ready);
        $display("mid reset done");
        own_bus = 1'b0;
        req_valid = 1'b1;
        repeat (8) @(posedge clk) #1;
        chk("req_ready", 0, req_ready);
        chk("cs_idle", 1, chip_sel_n_o);
        chk("addr_oe", 0, addr_oe);
        chk("rp_oe", 0, reset_power_down_n_oe);
        req_valid = 1'b0;
        $display("release done");
        wrap_up();
    end
endmodule // tb_top

bind efbp_ctrl efbp_monitor mon (.clk, .rst, .own_bus, .chip_sel_n_o,
    .out_en_n_o, .wr_strobe_n_o, .dq_oe, .ctrl_oe, .addr_oe, .density,
    .reset_power_down_n_o, .reset_power_down_n_oe, .addr_o);

/* File: verilog/efbp_ctrl.sv */
// External master for a configuration device's parallel flash bus.
// Assumes the device's configuration controller has been released or
// held in reset before own_bus is raised; pins sampled on clk.
`timescale 1ns/1ns
// Operation
// - Master drives data in command/write cycles
// - Release reset line when not using flash (released only in PARK; driven high in IDLE while the bus is owned)
// - Output enable low during reads enables drivers
// - Write strobe pulse; flash captures on rise
// - Word width fixed sixteen bits, full words
// - Access only after controller released bus
module efbp_ctrl
    import efbp_pkg::*;
#(
    parameter int ADDR_W = efbp_pkg::EFBP_ADDR_W,
    parameter int DATA_W = efbp_pkg::EFBP_DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic own_bus,
    input wire logic [1:0] density,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_reset,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic flash_ready,
    output logic [ADDR_W-1:0] addr_o,
    output logic addr_oe,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe,
    output logic chip_sel_n_o,
    output logic out_en_n_o,
    output logic wr_strobe_n_o,
    output logic ctrl_oe,
    output logic reset_power_down_n_o,
    output logic reset_power_down_n_oe,
    input wire logic ready_busy_n_i
);
    import efbp_pkg::*;

    efbp_state_t state_reg;
    efbp_state_t state_next;
    logic write_reg;
    logic load;
    logic [EFBP_CNT_W-1:0] load_cnt;
    logic expired;
    logic taking;
    logic read_end;

    // Clear address bits the chosen density does not decode
    function automatic logic [ADDR_W-1:0] mask_addr(
        input logic [ADDR_W-1:0] a,
        input logic [1:0] d);
        logic [ADDR_W-1:0] m;
        m = '1;
        m = m >> d;
        return a & m;
    endfunction

    // Select low through setup, pulse and hold
    function automatic logic in_access(input efbp_state_t s);
        return (s == EFBP_SETUP) || (s == EFBP_PULSE) || (s == EFBP_HOLD);
    endfunction

    // Each phase lasts its count plus one cycle, giving margin
    efbp_timer #(.CNT_W(EFBP_CNT_W)) u_timer (
        .clk(clk),
        .rst(rst),
        .load(load),
        .count(load_cnt),
        .expired(expired)
    );

    // A request is taken only in IDLE while the bus is ours
    assign taking = (state_reg == EFBP_IDLE) && req_valid && own_bus;
    // Last cycle of a read pulse, enable still low at this edge
    assign read_end = (state_reg == EFBP_PULSE) && expired && !write_reg;

    always_comb begin
        state_next = state_reg;
        load = 1'b0;
        load_cnt = '0;
        case (state_reg)
            EFBP_PARK: begin
                if (own_bus) begin
                    state_next = EFBP_IDLE;
                end
            end
            EFBP_IDLE: begin
                // Reset request wins over a write
                if (!own_bus) begin
                    state_next = EFBP_PARK;
                end else if (req_valid && req_reset) begin
                    state_next = EFBP_RST;
                    load = 1'b1;
                    load_cnt = EFBP_CNT_W'(EFBP_T_RST_CYC);
                end else if (req_valid) begin
                    state_next = EFBP_SETUP;
                    load = 1'b1;
                    load_cnt = EFBP_CNT_W'(EFBP_T_SETUP_CYC);
                end
            end
            EFBP_SETUP: begin
                if (expired) begin
                    state_next = EFBP_PULSE;
                    load = 1'b1;
                    load_cnt = EFBP_CNT_W'(EFBP_T_PULSE_CYC);
                end
            end
            EFBP_PULSE: begin
                if (expired) begin
                    state_next = EFBP_HOLD;
                    load = 1'b1;
                    load_cnt = EFBP_CNT_W'(EFBP_T_HOLD_CYC);
                end
            end
            EFBP_HOLD: begin
                if (expired) begin
                    state_next = EFBP_DONE;
                end
            end
            EFBP_RST: begin
                if (expired) begin
                    state_next = EFBP_DONE;
                end
            end
            EFBP_DONE: begin
                // One spare cycle keeps strobe edges of accesses apart
                state_next = EFBP_IDLE;
            end
            default: begin
                state_next = EFBP_PARK;
            end
        endcase
    end

    // Park after reset: nothing driven until own_bus rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= EFBP_PARK;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request capture; address and data stay put through hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_reg <= 1'b0;
            addr_o <= '0;
            dq_o <= '0;
        end else if (taking) begin
            // Masked once here with the density at capture; after a density change the pins keep the old top bits until the next request
            write_reg <= req_write && !req_reset;
            addr_o <= mask_addr(req_addr, density);
            dq_o <= req_wdata;
        end
    end

    // Read data sampled at end of the enable pulse, before release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_rdata <= '0;
        end else if (read_end) begin
            rsp_rdata <= dq_i;
        end
    end

    // Completion pulse coincides with the DONE state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (state_next == EFBP_DONE);
        end
    end

    // Strobes and enables; all registered to avoid glitches on pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Deselected and released; board pull-ups hold the levels
            chip_sel_n_o <= 1'b1;
            out_en_n_o <= 1'b1;
            wr_strobe_n_o <= 1'b1;
            ctrl_oe <= 1'b0;
            addr_oe <= 1'b0;
            dq_oe <= 1'b0;
            reset_power_down_n_o <= 1'b1;
            reset_power_down_n_oe <= 1'b0;
            flash_ready <= 1'b0;
        end else begin
            // Undriven in PARK, entered from IDLE once own_bus is low
            ctrl_oe <= (state_next != EFBP_PARK);
            addr_oe <= (state_next != EFBP_PARK);
            // Drive reset line while owned, high except in RST; release otherwise
            reset_power_down_n_oe <= (state_next != EFBP_PARK);
            // Reset op keeps select high, so no access overlaps it
            reset_power_down_n_o <= (state_next != EFBP_RST);
            chip_sel_n_o <= !in_access(state_next);
            // Write pulse; rising edge at pulse end latches
            wr_strobe_n_o <= !(state_next == EFBP_PULSE && write_reg);
            // Read enable
            out_en_n_o <= !((state_next == EFBP_PULSE) && !write_reg);
            // Data driven only on writes, through hold
            // At the taking edge write_reg still holds the last access
            dq_oe <= (taking ? req_write : write_reg) && in_access(state_next);
            // Open-drain output, high when ready
            flash_ready <= ready_busy_n_i;
        end
    end

    // Write protect is never an output of this block
    // Combinational so a request is taken on the first IDLE edge
    assign req_ready = (state_reg == EFBP_IDLE) && own_bus;
endmodule // efbp_ctrl

/* File: verilog/efbp_pkg.sv */
// Constants for the external flash bus port controller.
// Assumes a 100 MHz system clock driving all controller logic.
package efbp_pkg;
    localparam int EFBP_ADDR_W = 21;
    localparam int EFBP_DATA_W = 16;
    localparam int EFBP_CLK_MHZ = 100;
    // Bus phase times in ns
    localparam int EFBP_T_SETUP_NS = 40;
    localparam int EFBP_T_PULSE_NS = 70;
    localparam int EFBP_T_HOLD_NS = 20;
    localparam int EFBP_T_RST_NS = 100;
    localparam int EFBP_T_SETUP_CYC = (EFBP_T_SETUP_NS * EFBP_CLK_MHZ
        + 999) / 1000;
    localparam int EFBP_T_PULSE_CYC = (EFBP_T_PULSE_NS * EFBP_CLK_MHZ
        + 999) / 1000;
    localparam int EFBP_T_HOLD_CYC = (EFBP_T_HOLD_NS * EFBP_CLK_MHZ
        + 999) / 1000;
    localparam int EFBP_T_RST_CYC = (EFBP_T_RST_NS * EFBP_CLK_MHZ
        + 999) / 1000;
    localparam int EFBP_CNT_W = 8;
    // Density codes: number of unused top address bits
    localparam logic [1:0] EFBP_DENS_LARGE = 2'h1;
    localparam logic [1:0] EFBP_DENS_MID = 2'h2;
    localparam logic [1:0] EFBP_DENS_SMALL = 2'h3;
    typedef enum logic [6:0] {
        EFBP_IDLE = 7'h01,
        EFBP_SETUP = 7'h02,
        EFBP_PULSE = 7'h04,
        EFBP_HOLD = 7'h08,
        EFBP_RST = 7'h10,
        EFBP_DONE = 7'h20,
        EFBP_PARK = 7'h40
    } efbp_state_t;
endpackage

/* File: verilog/efbp_timer.sv */
// Down counter timing each bus phase.
// Assumes load and the count come from the controller state machine.
`timescale 1ns/1ns
module efbp_timer #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [CNT_W-1:0] count,
    output logic expired
);
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Not gated by load: load is itself decoded from expired
    assign expired = (cnt_reg == '0);
endmodule // efbp_timer
